//--- src/csr_core_params.svh
// Purpose: Offsets, field positions, reset values for the core registers
// Assumes: 8-bit data space, special area below 80h
// Notes: Offsets are register indices; the bus byte address is four times the index
`ifndef CSR_CORE_PARAMS_SVH
`define CSR_CORE_PARAMS_SVH
`define CSR_IDX_PORT0   8'h00
`define CSR_IDX_PTR0    8'h01
`define CSR_IDX_PORT1   8'h02
`define CSR_IDX_PTR1    8'h03
`define CSR_IDX_BANK    8'h04
`define CSR_IDX_ACC     8'h05
`define CSR_IDX_PCL     8'h06
`define CSR_IDX_TABLE_PTR_LOW    8'h07
`define CSR_IDX_TABLE_DATA_HIGH    8'h08
`define CSR_IDX_TABLE_PTR_HIGH    8'h09
`define CSR_IDX_STATUS  8'h0a
`define CSR_GP_BASE     8'h80
`define CSR_ST_C        0
`define CSR_ST_NC       1
`define CSR_ST_Z        2
`define CSR_ST_OV       3
`define CSR_ST_HALT     4
`define CSR_ST_WDX      5
`define CSR_RST_BYTE    8'h00
`endif

//--- src/csr_core_pkg.sv
// Purpose: Types for the core special register block
// Assumes: Datapath issues at most one ALU operation per cycle
// Notes: Op codes are one-hot
package csr_core_pkg;
  typedef enum logic [5:0] {
    CSR_OP_NONE  = 6'h01,
    CSR_OP_ADD   = 6'h02,
    CSR_OP_SUB   = 6'h04,
    CSR_OP_LOGIC = 6'h08,
    CSR_OP_RLC   = 6'h10,
    CSR_OP_RRC   = 6'h20
  } csr_op_t;
endpackage : csr_core_pkg

//--- src/csr_core.sv
// Purpose: Special registers, banked data memory and status flags of the core
// Assumes: Datapath inputs synchronous to clk_i; APB for software/debug access
// Notes: Data memory read data appears one cycle after the request
//
// Our own choices: the placing of the registers and the APB register port.
`include "csr_core_params.svh"
module csr_core
  import csr_core_pkg::*;
#(
  parameter int GP_DEPTH = 128,
  parameter int PC_W     = 13
) (
  input  wire logic            clk_i,
  input  wire logic            reset_i,
  input  wire logic            soft_rst_i,
  input  wire logic            wdt_rst_i,
  input  wire logic            wdt_timeout_i,
  input  wire logic            halt_i,
  input  wire logic            kick_i,
  input  wire logic [7:0]      dp_addr_i,
  input  wire logic            dp_rd_i,
  input  wire logic            dp_wr_i,
  output logic      [7:0]      dp_rdata_o,
  input  wire csr_op_t         alu_op_i,
  input  wire logic [7:0]      alu_a_i,
  input  wire logic [7:0]      alu_b_i,
  input  wire logic            acc_ld_i,
  output logic      [7:0]      acc_o,
  input  wire logic [PC_W-1:0] pc_i,
  output logic                 pc_jump_o,
  output logic      [PC_W-1:0] pc_target_o,
  output logic                 dummy_cycle_o,
  input  wire logic            tbl_rd_i,
  input  wire logic [15:0]     tbl_word_i,
  output logic      [15:0]     tbl_addr_o,
  output logic      [7:0]      tbl_low_o,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] pointer_zero_q;
  logic [7:0] pointer_one_q;
  logic       bank_select_bit_q;
  logic [7:0] alu_result_holder_q;
  logic [7:0] table_ptr_low_q;
  logic [7:0] table_ptr_high_q;
  logic [7:0] table_data_high_q;
  logic [3:0] arith_q;
  logic       halted_flag_q;
  logic       watchdog_expired_flag_q;
  logic [7:0] gp_mem [2][GP_DEPTH];

  // ****************************************
  // Address resolution
  // ****************************************
  logic       dp_act;
  logic       apb_wr;
  logic       apb_rd;
  logic [7:0] eff_addr;
  logic       eff_bank;
  logic       eff_null;
  logic       eff_sfr;
  logic [6:0] gp_idx;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] alu_res;
  logic [7:0] status_rd;

  assign dp_act = dp_rd_i | dp_wr_i;

  always_comb begin
    eff_addr = dp_addr_i;
    eff_bank = 1'b0;
    eff_null = 1'b0;
    if (dp_addr_i == `CSR_IDX_PORT0) begin
      eff_addr = pointer_zero_q;
      eff_bank = 1'b0;
      eff_null = (pointer_zero_q == `CSR_IDX_PORT0) ||
                 (pointer_zero_q == `CSR_IDX_PORT1);
    end else if (dp_addr_i == `CSR_IDX_PORT1) begin
      eff_addr = pointer_one_q;
      eff_bank = bank_select_bit_q;
      eff_null = (pointer_one_q == `CSR_IDX_PORT0) ||
                 (pointer_one_q == `CSR_IDX_PORT1);
    end
  end

  // Special area ignores the bank; only general memory is banked
  assign eff_sfr = eff_addr < `CSR_GP_BASE;
  assign gp_idx  = eff_addr[6:0];

  assign status_rd = {2'b00, watchdog_expired_flag_q, halted_flag_q, arith_q};

  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `CSR_IDX_PTR0:   r = pointer_zero_q;
      `CSR_IDX_PTR1:   r = pointer_one_q;
      `CSR_IDX_BANK:   r = {7'h00, bank_select_bit_q};
      `CSR_IDX_ACC:    r = alu_result_holder_q;
      `CSR_IDX_PCL:    r = pc_i[7:0];
      `CSR_IDX_TABLE_PTR_LOW:   r = table_ptr_low_q;
      `CSR_IDX_TABLE_DATA_HIGH:   r = table_data_high_q;
      `CSR_IDX_TABLE_PTR_HIGH:   r = table_ptr_high_q;
      `CSR_IDX_STATUS: r = status_rd;
      default:         r = 8'h00;
    endcase
    return r;
  endfunction : sfr_read

  // ****************************************
  // ALU and flags
  // ****************************************
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum7;
  logic [3:0] flags_d;
  logic       flags_upd;

  always_comb begin
    sum9      = 9'h000;
    sum5      = 5'h00;
    sum7      = 8'h00;
    alu_res   = alu_b_i;
    flags_d   = arith_q;
    flags_upd = 1'b1;
    unique case (alu_op_i)
      CSR_OP_ADD, CSR_OP_SUB: begin
        // Subtract as a + ~b + 1, so carry out means no borrow
        if (alu_op_i == CSR_OP_ADD) begin
          sum9 = {1'b0, alu_a_i} + {1'b0, alu_b_i};
          sum5 = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]};
          sum7 = {1'b0, alu_a_i[6:0]} + {1'b0, alu_b_i[6:0]};
        end else begin
          sum9 = {1'b0, alu_a_i} + {1'b0, ~alu_b_i} + 9'h001;
          sum5 = {1'b0, alu_a_i[3:0]} + {1'b0, ~alu_b_i[3:0]} + 5'h01;
          sum7 = {1'b0, alu_a_i[6:0]} + {1'b0, ~alu_b_i[6:0]} + 8'h01;
        end
        alu_res            = sum9[7:0];
        flags_d[`CSR_ST_C]  = sum9[8];
        flags_d[`CSR_ST_NC] = sum5[4];
        flags_d[`CSR_ST_Z]  = sum9[7:0] == 8'h00;
        flags_d[`CSR_ST_OV] = sum7[7] ^ sum9[8];
      end
      CSR_OP_LOGIC: begin
        flags_d[`CSR_ST_Z] = alu_b_i == 8'h00;
      end
      CSR_OP_RLC: begin
        alu_res            = {alu_a_i[6:0], arith_q[`CSR_ST_C]};
        flags_d[`CSR_ST_C] = alu_a_i[7];
      end
      CSR_OP_RRC: begin
        alu_res            = {arith_q[`CSR_ST_C], alu_a_i[7:1]};
        flags_d[`CSR_ST_C] = alu_a_i[0];
      end
      default: flags_upd = 1'b0;
    endcase
  end

  // Datapath writes carry the ALU result and APB writes carry pwdata[7:0], never another location
  assign wr_en   = (dp_wr_i && !eff_null) || apb_wr;
  assign wr_data = dp_wr_i ? alu_res : pwdata[7:0];

  // ****************************************
  // APB slave
  // ****************************************
  logic [7:0] apb_idx;
  logic       apb_bad;

  assign apb_idx = paddr[9:2];
  assign apb_bad = (paddr[31:10] != 22'h000000) || (apb_idx > `CSR_IDX_STATUS);
  // Datapath owns the port; APB waits rather than racing it
  assign pready  = !dp_act;
  assign pslverr = psel && penable && apb_bad;
  assign apb_wr  = psel && penable && pwrite && pready && !apb_bad;
  assign apb_rd  = psel && !pwrite;
  assign prdata  = apb_rd ? {24'h000000, sfr_read(apb_idx)} : 32'h00000000;

  logic [7:0] wr_addr;
  assign wr_addr = apb_wr ? apb_idx : eff_addr;
  logic       wr_sfr;
  assign wr_sfr = wr_en && (apb_wr || eff_sfr);

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pointer_zero_q <= `CSR_RST_BYTE;
      pointer_one_q  <= `CSR_RST_BYTE;
    end else if (wr_sfr) begin
      if (wr_addr == `CSR_IDX_PTR0) pointer_zero_q <= wr_data;
      if (wr_addr == `CSR_IDX_PTR1) pointer_one_q  <= wr_data;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bank_select_bit_q <= 1'b0;
    end else if (soft_rst_i || (wdt_rst_i && !halted_flag_q)) begin
      bank_select_bit_q <= 1'b0;
    end else if (wr_sfr && wr_addr == `CSR_IDX_BANK) begin
      bank_select_bit_q <= wr_data[0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      alu_result_holder_q <= `CSR_RST_BYTE;
    end else if (acc_ld_i) begin
      alu_result_holder_q <= alu_res;
    end else if (wr_sfr && wr_addr == `CSR_IDX_ACC) begin
      alu_result_holder_q <= wr_data;
    end
  end
  assign acc_o = alu_result_holder_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_jump_o     <= 1'b0;
      pc_target_o   <= '0;
      dummy_cycle_o <= 1'b0;
    end else begin
      pc_jump_o     <= wr_sfr && wr_addr == `CSR_IDX_PCL;
      dummy_cycle_o <= wr_sfr && wr_addr == `CSR_IDX_PCL;
      if (wr_sfr && wr_addr == `CSR_IDX_PCL) begin
        pc_target_o <= {pc_i[PC_W-1:8], wr_data};
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      table_ptr_low_q  <= `CSR_RST_BYTE;
      table_ptr_high_q <= `CSR_RST_BYTE;
    end else if (wr_sfr) begin
      if (wr_addr == `CSR_IDX_TABLE_PTR_LOW) table_ptr_low_q  <= wr_data;
      if (wr_addr == `CSR_IDX_TABLE_PTR_HIGH) table_ptr_high_q <= wr_data;
    end
  end
  // Pointers are trusted as loaded; no check for a stale setup
  assign tbl_addr_o = {table_ptr_high_q, table_ptr_low_q};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      table_data_high_q <= `CSR_RST_BYTE;
      tbl_low_o         <= `CSR_RST_BYTE;
    end else if (tbl_rd_i) begin
      table_data_high_q <= tbl_word_i[15:8];
      tbl_low_o         <= tbl_word_i[7:0];
    end else if (wr_sfr && wr_addr == `CSR_IDX_TABLE_DATA_HIGH) begin
      table_data_high_q <= wr_data;
    end
  end

  // Flags are not stacked; software saves status itself
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      arith_q <= 4'h0;
    end else if (wr_sfr && wr_addr == `CSR_IDX_STATUS) begin
      arith_q <= wr_data[3:0];
    end else if (flags_upd) begin
      arith_q <= flags_d;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      halted_flag_q <= 1'b0;
    end else if (halt_i) begin
      halted_flag_q <= 1'b1;
    end else if (kick_i) begin
      halted_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      watchdog_expired_flag_q <= 1'b0;
    end else if (wdt_timeout_i) begin
      watchdog_expired_flag_q <= 1'b1;
    end else if (kick_i || halt_i) begin
      watchdog_expired_flag_q <= 1'b0;
    end
  end

  // ****************************************
  // General data memory
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (wr_en && !apb_wr && !eff_sfr) begin
      gp_mem[eff_bank][gp_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dp_rdata_o <= `CSR_RST_BYTE;
    end else if (dp_rd_i) begin
      if (eff_null) begin
        dp_rdata_o <= 8'h00;
      end else if (eff_sfr) begin
        dp_rdata_o <= sfr_read(eff_addr);
      end else begin
        dp_rdata_o <= gp_mem[eff_bank][gp_idx];
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_pcl_write;
    wr_sfr && wr_addr == `CSR_IDX_PCL;
  endsequence

  sequence s_jump_out;
    pc_jump_o && dummy_cycle_o;
  endsequence

  a_pcl_dummy: assert property (@(posedge clk_i) disable iff (reset_i)
    s_pcl_write |=> s_jump_out ##1 !dummy_cycle_o)
    else $error("PROG_COUNTER_LOW write without single dummy cycle");

  a_pcl_page: assert property (@(posedge clk_i) disable iff (reset_i)
    s_pcl_write |=> pc_target_o == {$past(pc_i[PC_W-1:8]), $past(wr_data)})
    else $error("PROG_COUNTER_LOW jump left page");

  a_port_null: assert property (@(posedge clk_i) disable iff (reset_i)
    dp_rd_i && eff_null |=> dp_rdata_o == 8'h00)
    else $error("Indirect port read not zero");

  a_bank_upper: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_sfr && wr_addr == `CSR_IDX_BANK && !soft_rst_i && !wdt_rst_i
      |=> sfr_read(`CSR_IDX_BANK) == {7'h00, $past(wr_data[0])})
    else $error("Bank select upper bits set");

  a_bank_reset: assert property (@(posedge clk_i) disable iff (reset_i)
    soft_rst_i || (wdt_rst_i && !halted_flag_q) |=> !bank_select_bit_q)
    else $error("Bank not cleared by reset");

  a_bank_keep: assert property (@(posedge clk_i) disable iff (reset_i)
    wdt_rst_i && halted_flag_q && !soft_rst_i && !wr_sfr
      |=> $stable(bank_select_bit_q))
    else $error("Bank changed by halted watchdog reset");

  a_sys_flags: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_sfr && wr_addr == `CSR_IDX_STATUS && !halt_i && !kick_i && !wdt_timeout_i
      |=> $stable(status_rd[5:4]))
    else $error("Status write touched system flags");

  a_halt_set: assert property (@(posedge clk_i) disable iff (reset_i)
    halt_i |=> halted_flag_q && (watchdog_expired_flag_q == $past(wdt_timeout_i)))
    else $error("Halt flag handling wrong");

  a_wdx_set: assert property (@(posedge clk_i) disable iff (reset_i)
    wdt_timeout_i |=> watchdog_expired_flag_q)
    else $error("Time-out did not set flag");

  a_add_carry: assert property (@(posedge clk_i) disable iff (reset_i)
    alu_op_i == CSR_OP_ADD && !wr_sfr
      |=> arith_q[`CSR_ST_C] == ($past({1'b0, alu_a_i}) + $past({1'b0, alu_b_i}) > 9'h0ff))
    else $error("Carry wrong after add");

  a_table_high: assert property (@(posedge clk_i) disable iff (reset_i)
    tbl_rd_i |=> table_data_high_q == $past(tbl_word_i[15:8]))
    else $error("Table high byte not captured");

endmodule : csr_core

//--- sim/csr_prog_mem.sv
// Purpose: Program memory model that answers table reads
// Assumes: Word is a fixed function of the table address
// Notes: Pattern keeps the high and low bytes distinct except where the two address bytes XOR to 55h
module csr_prog_mem (
  input  wire logic [15:0] addr_i,
  output logic      [15:0] word_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Zero latency; the core samples the word at the read edge
  assign word_o = addr_i ^ 16'h5a0f;
endmodule : csr_prog_mem

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the core special register block
// Assumes: APB and datapath never active together
// Notes: Flag rows are worked out by hand from the flag definitions
module tb_top
  import csr_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk_i, reset_i, e;
  logic [4:0]  sys_q; // soft, wdt reset, timeout, halt, kick
  logic [7:0]  dp_addr_i, alu_a_i, alu_b_i, dp_rdata_o, acc_o, tbl_low_o;
  logic        dp_rd_i, dp_wr_i, acc_ld_i, pc_jump_o, dummy_cycle_o, tbl_rd_i;
  csr_op_t     alu_op_i;
  logic [12:0] pc_i, pc_target_o;
  logic [15:0] tbl_word_i, tbl_addr_o;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  int          err_total, samples_checked;
  localparam logic [47:0] FT [8] = '{
    48'h02_7f_01_80_0a_0f, 48'h02_ff_01_00_07_0f, 48'h04_05_03_02_03_0f,
    48'h04_03_05_fe_00_0f, 48'h04_80_01_7f_09_0f, 48'h10_40_00_81_00_01,
    48'h20_01_00_00_01_01, 48'h08_00_00_00_04_04};
  csr_core uut (.clk_i, .reset_i, .soft_rst_i(sys_q[4]), .wdt_rst_i(sys_q[3]),
    .wdt_timeout_i(sys_q[2]), .halt_i(sys_q[1]), .kick_i(sys_q[0]), .dp_addr_i,
    .dp_rd_i, .dp_wr_i, .dp_rdata_o, .alu_op_i, .alu_a_i, .alu_b_i, .acc_ld_i,
    .acc_o, .pc_i, .pc_jump_o, .pc_target_o, .dummy_cycle_o, .tbl_rd_i,
    .tbl_word_i, .tbl_addr_o, .tbl_low_o, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  csr_prog_mem u_mem (.addr_i(tbl_addr_o), .word_o(tbl_word_i));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] s, x);
    samples_checked++;
    if (s !== x) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // Waits on pready; the slave stalls while the datapath is busy
  task automatic apb(input logic w, input logic [7:0] i, d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    // No cycle limit here; a stuck slave is caught by the watchdog
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ar(input logic [7:0] i, input logic [31:0] x, input string n);
    apb(1'b0, i, 8'h00);
    chk(n, rd, x);
  endtask : ar
  task automatic dp(input logic [7:0] ad, input logic r, w, l, input csr_op_t op,
                    input logic [7:0] a, b);
    @(posedge clk_i);
    dp_addr_i <= ad;
    dp_rd_i <= r;
    dp_wr_i <= w;
    acc_ld_i <= l;
    alu_op_i <= op;
    alu_a_i <= a;
    alu_b_i <= b;
    @(posedge clk_i);
    dp_rd_i <= 1'b0;
    dp_wr_i <= 1'b0;
    acc_ld_i <= 1'b0;
    alu_op_i <= CSR_OP_NONE;
  endtask : dp
  task automatic wr(input logic [7:0] a, v);
    dp(a, 1'b0, 1'b1, 1'b0, CSR_OP_LOGIC, 8'h00, v);
  endtask : wr
  task automatic dr(input logic [7:0] a, x, input string n);
    dp(a, 1'b1, 1'b0, 1'b0, CSR_OP_NONE, 8'h00, 8'h00);
    #1;
    chk(n, dp_rdata_o, x);
  endtask : dr
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_i);
    sys_q <= m;
    @(posedge clk_i);
    sys_q <= 5'h00;
  endtask : pulse
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_flags;
    for (int k = 0; k < 8; k++) begin
      dp(8'h80, 1'b0, 1'b0, 1'b1, csr_op_t'(FT[k][45:40]), FT[k][39:32], FT[k][31:24]);
      #1;
      chk("acc", acc_o, FT[k][23:16]);
      apb(1'b0, 8'h0a, 8'h00);
      chk("flags", rd & FT[k][7:0], FT[k][15:8]);
    end
    $display("flags test done");
  endtask : t_flags
  task automatic t_mem;
    apb(1'b1, 8'h04, 8'hff);
    ar(8'h04, 32'h01, "bank_rb");
    apb(1'b1, 8'h03, 8'h80);
    apb(1'b1, 8'h01, 8'h80);
    wr(8'h02, 8'h5a);
    wr(8'h80, 8'h33);
    dr(8'h02, 8'h5a, "port1_b1");
    dr(8'h80, 8'h33, "direct");
    dr(8'h00, 8'h33, "port0");
    apb(1'b1, 8'h04, 8'h00);
    dr(8'h02, 8'h33, "port1_b0");
    ar(8'h03, 32'h80, "ptr1");
    ar(8'h00, 32'h00, "port0_apb");
    apb(1'b1, 8'h03, 8'h02);
    wr(8'h02, 8'h77);
    dr(8'h02, 8'h00, "self_rd");
    ar(8'h03, 32'h02, "self_wr");
    apb(1'b1, 8'h04, 8'h01);
    apb(1'b1, 8'h03, 8'h04);
    dr(8'h02, 8'h01, "sfr_b1");
    wr(8'h01, 8'h81);
    ar(8'h01, 32'h81, "ptr0_dp");
    $display("memory test done");
  endtask : t_mem
  task automatic t_sys;
    // Earlier tests leave arithmetic flags behind; pin them first
    apb(1'b1, 8'h0a, 8'h04);
    pulse(5'h02);
    ar(8'h0a, 32'h14, "halt");
    pulse(5'h04);
    ar(8'h0a, 32'h34, "expire");
    apb(1'b1, 8'h0a, 8'h00);
    ar(8'h0a, 32'h30, "st_wr0");
    apb(1'b1, 8'h0a, 8'hcf);
    ar(8'h0a, 32'h3f, "st_wr1");
    apb(1'b1, 8'h04, 8'h01);
    pulse(5'h08);
    ar(8'h04, 32'h01, "wdt_halted");
    pulse(5'h01);
    ar(8'h0a, 32'h0f, "kick");
    pulse(5'h08);
    ar(8'h04, 32'h00, "wdt_run");
    apb(1'b1, 8'h04, 8'h01);
    pulse(5'h10);
    ar(8'h04, 32'h00, "soft");
    pulse(5'h06);
    ar(8'h0a, 32'h3f, "halt_tmo");
    $display("system flag test done");
  endtask : t_sys
  task automatic t_pcl_tbl;
    apb(1'b1, 8'h07, 8'h34);
    apb(1'b1, 8'h09, 8'h12);
    #1;
    chk("tbl_addr", tbl_addr_o, 16'h1234);
    @(posedge clk_i);
    tbl_rd_i <= 1'b1;
    @(posedge clk_i);
    tbl_rd_i <= 1'b0;
    #1;
    chk("tbl_low", tbl_low_o, 8'h3b);
    ar(8'h08, 32'h48, "tbl_high");
    wr(8'h06, 8'h3c);
    #1;
    chk("jump", {pc_jump_o, dummy_cycle_o, pc_target_o}, {2'b11, 13'h1a3c});
    @(posedge clk_i);
    #1;
    chk("jump_end", {pc_jump_o, dummy_cycle_o}, 2'b00);
    apb(1'b1, 8'h06, 8'hc3);
    #1;
    chk("jump_apb", {pc_jump_o, pc_target_o}, {1'b1, 13'h1ac3});
    $display("pcl and table test done");
  endtask : t_pcl_tbl
  task automatic t_por;
    apb(1'b1, 8'h04, 8'h01);
    pulse(5'h02);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    ar(8'h04, 32'h00, "por_bank");
    ar(8'h0a, 32'h00, "por_status");
    $display("power-up test done");
  endtask : t_por
  // ****************************************
  // Run
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #3_000_000;
    err_total++;
    end_of_test;
  end
  initial begin
    {reset_i, sys_q, psel, penable, pwrite, paddr, pwdata} = '0;
    reset_i = 1'b1;
    {dp_addr_i, alu_a_i, alu_b_i, dp_rd_i, dp_wr_i, acc_ld_i, tbl_rd_i} = '0;
    alu_op_i = CSR_OP_NONE;
    pc_i = 13'h1a55;
    err_total = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    ar(8'h04, 32'h00, "bank_rst");
    ar(8'h0a, 32'h00, "status_rst");
    apb(1'b0, 8'h0b, 8'h00);
    chk("unmapped", {e, rd}, {1'b1, 32'h0});
    $display("reset test done");
    t_flags;
    t_mem;
    t_sys;
    t_pcl_tbl;
    t_por;
    end_of_test;
  end
endmodule : tb_top
